//--- dac_host_regs.vh
// Constants for the serial DAC host framing controller.
// Assumes a 50 MHz reference clock and a DAC sampling on falling shift-clock edges.
// Contract
// RULE1: A sample-and-hold channel select is one frame of exactly 10 bits.
// RULE2: A DAC load may go as three consecutive bytes inside one frame.
// RULE3: Readback data is captured as a 16-bit receive word.
// RULE4: Clock idles low, data changes on rising edge, valid at falling edge.
// RULE5: Frame sync stays low for the whole transmission.
// RULE6: Frame sync goes high and low again before every new cycle.
// RULE7: Ten-bit words sit left-justified, most significant first, in byte stream.
// RULE8: Byte-wide hosts send two or three transfers per frame by mode.
// RULE9: Device shifts out on rising edge and latches in on falling edge.
// RULE10: Words travel most significant bit first both ways.
// RULE11: A least-significant-first shifter must reverse each word first.
// RULE12: Shift clock is synchronous with data, no asynchronous framing.
// RULE13: Sync falling edge restarts the device bit counter.
// RULE14: Device data out drives from first rising edge to fourteenth falling edge.
// RULE15: At least 400 ns between successive DAC load writes.
// RULE16: First two word bits pick mode: 00 hold, 01 load, 10 acquire, 11 readback.
`ifndef DAC_HOST_REGS_VH
`define DAC_HOST_REGS_VH
`define CLK_MHZ          50
`define GAP_NS           400
`define GAP_CYC          ((`GAP_NS * `CLK_MHZ + 999) / 1000)
`define MODE_SHA         2'h0
`define MODE_DAC         2'h1
`define MODE_ACQ_RB      2'h2
`define MODE_RB          2'h3
`define LEN_SHA          5'h0A
`define LEN_DAC          5'h18
`define LEN_RB           5'h10
`define BYTES_SHA        2'h2
`define BYTES_DAC        2'h3
`define DIV_HALF         4
`endif

//--- dac_host_sva.sv
// Checker for the serial DAC host framing controller.
// Assumes the default DIV_HALF of 4 and clk_en held high within frames.
`timescale 1ns/10ps
`default_nettype none
module dac_host_sva (
   input wire logic       ref_clk,
   input wire logic       resetn,
   input wire logic       busy,
   input wire logic       done,
   input wire logic       sclk,
   input wire logic       mosi,
   input wire logic       sync_n,
   input wire logic [4:0] host_word_length
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   sequence frame_open;
      $fell(sync_n);
   endsequence
   sequence frame_close;
      $rose(sync_n);
   endsequence
   AST_SCLK_IDLE: assert property (sync_n |-> !sclk)
      else $error("shift clock active outside frame");
   AST_MOSI_FALL: assert property ($fell(sclk) |-> $stable(mosi))
      else $error("data moved at falling edge");
   AST_FIRST_EDGE: assert property (frame_open |-> !sclk[*4] ##1 sclk)
      else $error("first rise not four cycles after sync");
   AST_SYNC_LOW: assert property (frame_open |-> !sync_n[*8])
      else $error("sync rose early");
   AST_BUSY_FRAME: assert property (frame_open |-> busy)
      else $error("frame without busy");
   AST_DONE_EDGE: assert property (done |-> frame_close)
      else $error("done without sync rise");
   AST_DONE_PULSE: assert property (done |=> !done)
      else $error("done longer than one cycle");
   AST_GAP: assert property (frame_close |-> (sync_n && busy)[*8])
      else $error("gap between frames too short");
   AST_LEN: assert property (done |-> host_word_length inside {5'h0A, 5'h18, 5'h10})
      else $error("bad frame length");
endmodule
bind dac_serial_host_framing dac_host_sva chk (.ref_clk(ref_clk), .resetn(resetn),
   .busy(busy), .done(done), .sclk(sclk), .mosi(mosi), .sync_n(sync_n),
   .host_word_length(host_word_length));
`default_nettype wire

//--- dac_model.sv
// Behavioural DAC serial port: captures data in, shifts readback out.
// Assumes the host drives sclk, mosi and sync_n.
`timescale 1ns/10ps
`default_nettype none
module dac_model (
   input wire logic        sclk,
   input wire logic        sync_n,
   input wire logic        mosi,
   input wire logic [15:0] pat,
   output var logic        miso,
   output var logic [23:0] got,
   output var logic [4:0]  n
);
   initial miso = 1'b0;
   initial n = 5'h00;
   always @(negedge sync_n) {n, got} = 29'h0;
   always @(negedge sclk)
      if (!sync_n)
      begin
         got = {got[22:0], mosi};
         n = n + 5'h01;
         if (n == 5'h0E) miso = ~miso;
      end
   always @(posedge sclk) if (!sync_n && n < 5'h0E) miso = pat[5'h0F - n];
endmodule
`default_nettype wire

//--- dac_serial_host_framing.v
// Serial master driving the DAC's shift clock, data input and frame sync.
// Assumes the DAC data output is asynchronous to ref_clk and is synchronised here.
`timescale 1ns/10ps
`default_nettype none
`include "dac_host_regs.vh"
module dac_serial_host_framing #(
   parameter DIV_HALF = `DIV_HALF,
   parameter GAP_CYC  = `GAP_CYC
)(
   input  wire        ref_clk,
   input  wire        resetn,
   input  wire        clk_en,
   input  wire        start,
   input  wire        read_frame,
   input  wire        lsb_first,
   input  wire [23:0] tx_word,
   output reg         busy,
   output reg         done,
   output reg  [15:0] rx_word,
   output reg  [4:0]  host_word_length,
   output reg         sclk,
   output reg         mosi,
   output reg         sync_n,
   input  wire        miso
);
   localparam ST_IDLE = 3'h0;
   localparam ST_LEAD = 3'h1;
   localparam ST_LOW  = 3'h2;
   localparam ST_HIGH = 3'h3;
   localparam ST_END  = 3'h4;
   localparam ST_GAP  = 3'h5;

   reg  [2:0]  state_q;
   reg  [7:0]  div_q;
   reg  [4:0]  bits_q;
   reg  [23:0] sh_q;
   reg  [15:0] rx_q;
   reg  [8:0]  gap_q;
   reg         rd_q;
   reg         miso_m_q;
   reg         miso_s_q;
   wire [23:0] rev_word;
   wire [1:0]  mode;
   wire [23:0] eff_word;
   reg  [4:0]  len;
   reg  [23:0] load_word;
   reg  [2:0]  state_d;
   wire        run;
   wire        half_end;
   wire        take_go;
   wire        rise_go;
   wire        fall_go;
   wire        last_go;
   wire        end_go;
   wire        gap_end;

   genvar gi;
   generate
      for (gi = 0; gi < 24; gi = gi + 1)
      begin : g_rev
         assign rev_word[gi] = tx_word[23 - gi]; // see RULE11
      end
   endgenerate

   assign eff_word = lsb_first ? rev_word : tx_word;
   assign mode     = eff_word[23:22]; // see RULE16

   always @*
   begin
      load_word = eff_word;
      if (read_frame)
      begin
         len = `LEN_RB; // see RULE3
      end
      else if (mode == `MODE_DAC)
      begin
         len = `LEN_DAC; // see RULE2
      end
      else
      begin
         len = `LEN_SHA; // see RULE1
      end
   end

   // Two-flop synchroniser on the DAC data output
   always @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         miso_m_q <= 1'b0;
         miso_s_q <= 1'b0;
      end
      else if (clk_en)
      begin
         miso_m_q <= miso;
         miso_s_q <= miso_m_q;
      end
   end

   // Frame phase decode
   assign run      = (state_q == ST_LEAD) || (state_q == ST_HIGH) || (state_q == ST_LOW);
   assign half_end = run && (div_q == DIV_HALF[7:0] - 8'h01);
   assign take_go  = (state_q == ST_IDLE) && start;
   assign rise_go  = half_end && ((state_q == ST_LEAD) ||
                     ((state_q == ST_LOW) && (bits_q != 5'h01)));
   assign fall_go  = half_end && (state_q == ST_HIGH);
   assign last_go  = half_end && (state_q == ST_LOW) && (bits_q == 5'h01);
   assign end_go   = (state_q == ST_END);
   assign gap_end  = (state_q == ST_GAP) && (gap_q <= 9'h001);

   // Next state of the frame sequencer
   always @*
   begin
      state_d = state_q;
      case (state_q)
         ST_IDLE:
         begin
            if (start)
            begin
               state_d = ST_LEAD;
            end
         end
         ST_LEAD:
         begin
            if (half_end)
            begin
               state_d = ST_HIGH;
            end
         end
         ST_HIGH:
         begin
            if (half_end)
            begin
               state_d = ST_LOW;
            end
         end
         ST_LOW:
         begin
            if (last_go)
            begin
               state_d = ST_END;
            end
            else if (half_end)
            begin
               state_d = ST_HIGH;
            end
         end
         ST_END:
         begin
            state_d = ST_GAP;
         end
         ST_GAP:
         begin
            if (gap_end)
            begin
               state_d = ST_IDLE;
            end
         end
         default:
         begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // State and half-period divider
   always @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_q <= ST_IDLE;
         div_q   <= 8'h00;
      end
      else if (clk_en)
      begin
         state_q <= state_d;
         if (!run || half_end)
         begin
            div_q <= 8'h00;
         end
         else
         begin
            div_q <= div_q + 8'h01;
         end
      end
   end

   // Frame sync, busy and done
   always @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sync_n <= 1'b1;
         busy   <= 1'b0;
         done   <= 1'b0;
      end
      else if (clk_en)
      begin
         done <= end_go; // see RULE6
         if (take_go)
         begin
            sync_n <= 1'b0; // see RULE5
            busy   <= 1'b1;
         end
         else if (end_go)
         begin
            sync_n <= 1'b1; // see RULE6
         end
         else if (gap_end)
         begin
            busy <= 1'b0; // see RULE15
         end
      end
   end

   // Idle spacing after each frame, also the minimum DAC load spacing
   always @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         gap_q <= 9'h000;
      end
      else if (clk_en)
      begin
         if (end_go)
         begin
            gap_q <= GAP_CYC[8:0]; // see RULE15
         end
         else if ((state_q == ST_GAP) && !gap_end)
         begin
            gap_q <= gap_q - 9'h001;
         end
      end
   end

   // Frame length and bit counter
   always @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         bits_q           <= 5'h00;
         rd_q             <= 1'b0;
         host_word_length <= 5'h00;
      end
      else if (clk_en)
      begin
         if (take_go)
         begin
            host_word_length <= len; // see RULE1
            bits_q           <= len; // see RULE8
            rd_q             <= read_frame; // see RULE3
         end
         else if (half_end && (state_q == ST_LOW))
         begin
            bits_q <= bits_q - 5'h01;
         end
      end
   end

   // Shift clock and transmit shifter
   always @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sh_q <= 24'h000000;
         sclk <= 1'b0;
         mosi <= 1'b0;
      end
      else if (clk_en)
      begin
         if (take_go)
         begin
            // Word is left-justified so the first bit is bit 23
            sh_q <= load_word; // see RULE7
         end
         else if (rise_go)
         begin
            sclk <= 1'b1; // see RULE12
            mosi <= rd_q ? 1'b0 : sh_q[23]; // see RULE10
            sh_q <= {sh_q[22:0], 1'b0};
         end
         else if (fall_go || !run)
         begin
            sclk <= 1'b0; // see RULE4
         end
      end
   end

   // Receive at each fall; the device output is released at the fourteenth one
   always @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rx_q    <= 16'h0000;
         rx_word <= 16'h0000;
      end
      else if (clk_en)
      begin
         if (fall_go && rd_q)
         begin
            rx_q <= {rx_q[14:0], miso_s_q}; // see RULE3
         end
         if (end_go && rd_q)
         begin
            rx_word <= rx_q; // see RULE10
         end
      end
   end
endmodule
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the serial DAC host framing controller.
// Assumes dac_model on the far side and the checker bound to the design.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic        ref_clk = 0, resetn = 0, clk_en = 1, start = 0, read_frame = 0;
   logic        lsb_first = 0, miso, busy, done, sclk, mosi, sync_n;
   logic [23:0] tx_word = 0, got;
   logic [15:0] rx_word, pat = 0;
   logic [4:0]  host_word_length, n;
   int          num_errors = 0, checks = 0;
   dac_serial_host_framing dut (.ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en),
      .start(start), .read_frame(read_frame), .lsb_first(lsb_first), .tx_word(tx_word),
      .busy(busy), .done(done), .rx_word(rx_word), .host_word_length(host_word_length),
      .sclk(sclk), .mosi(mosi), .sync_n(sync_n), .miso(miso));
   dac_model m (.sclk(sclk), .sync_n(sync_n), .mosi(mosi), .pat(pat), .miso(miso),
      .got(got), .n(n));
   always #10 ref_clk = ~ref_clk;
   function automatic logic [23:0] ew(input logic [23:0] t, input logic l);
      for (int k = 0; k < 24; k++) ew[k] = l ? t[23 - k] : t[k];
   endfunction
   task chk(input logic [23:0] a, input logic [23:0] e);
      checks++;
      if (a !== e)
      begin
         num_errors++;
         $display("ERROR %0t got %h expected %h", $time, a, e);
      end
   endtask
   task results;
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task frame(input logic [23:0] t, input logic r, input logic l);
      logic [23:0] w;
      int          i, len;
      w = ew(t, l);
      len = r ? 16 : (w[23:22] == 2'h1 ? 24 : 10);
      @(negedge ref_clk);
      {tx_word, read_frame, lsb_first, start} = {t, r, l, 1'b1};
      pat = $urandom;
      @(negedge ref_clk);
      start = 0;
      for (i = 0; i < 900 && done !== 1'b1; i++) @(negedge ref_clk);
      chk(done, 1);
      chk(host_word_length, len);
      chk(n, len);
      if (r) chk(rx_word[15:2], pat[15:2]);
      else chk(got, w >> (24 - len));
      for (i = 0; i < 99 && busy === 1'b1; i++) @(negedge ref_clk);
      chk(busy, 0);
      chk(sync_n, 1);
   endtask
   initial
   begin
      #500000;
      num_errors++;
      results;
   end
   initial
   begin
      logic [23:0] t;
      void'($urandom(56968));
      repeat (10) @(negedge ref_clk);
      resetn = 1;
      for (int k = 0; k < 16; k++)
      begin
         t = $urandom;
         t[23:22] = k[1:0];
         frame(t, k[3] & ~k[2], k[2] & ~k[3]);
         clk_en = 0;
         repeat (3) @(negedge ref_clk);
         clk_en = 1;
      end
      frame(24'h7FFFFF, 1'b0, 1'b0);
      frame(24'h000001, 1'b0, 1'b1);
      frame(24'hFFFFFF, 1'b1, 1'b0);
      results;
   end
endmodule
`default_nettype wire
